// [design/eer_core_state.sv]
// Architectural register file and logical-to-physical address unit of a core.
`timescale 1ns/1ps
`default_nettype none
`include "eer_defines.svh"

// How it works
// - Sixteen general registers, each 64 bits wide, in wide mode.
// - General registers accept byte, word, doubleword and quadword operand sizes.
// - Byte access always selects the low eight bits of any register.
// - Instruction pointer is held as a full 64-bit register.
// - Flags are 64 bits; low half acts as 32-bit flags, upper reserved.
// - Stack pointer is always 64 bits, unaffected by descriptor or prefix.
// - Sixteen 128-bit and sixteen 256-bit vector registers are provided.
// - Control registers are 64 bits, plus a task priority control register.
// - Debug watch registers are widened to 64 bits.
// - Global and interrupt table registers hold limit plus 64-bit base, ten bytes.
// - Local table and task state registers hold a full 64-bit base.
// - Wide mode reaches canonical 64-bit linear and 46-bit physical space.
// - Physical memory is byte addressed; legacy range ends at 2^36 minus one.
// - Flat model uses one contiguous linear space up to 2^32 minus one.
// - Segmented address is selector plus offset; 16383 segments up to 4 GB.
// - Segmented accesses are translated to linear addresses transparently.
// - Real model uses 64 KB segments within a 2^20 byte linear space.
// - Five mode control registers set operating mode and task traits.
// - Model-specific registers are closed to user code except the time stamp.
// - Wide mode defaults to 64-bit addresses and 32-bit operands; prefix overrides.
module eer_core_state #(
  parameter int NUM_GPR = `EER_NUM_GPR,
  parameter int NUM_VEC = `EER_NUM_VEC,
  parameter int PHYS_W = `EER_PHYS_W_WIDE
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic wide_mode,
  input wire eer_pkg::eer_gpr_req_t gpr_req,
  input wire logic [3:0] gpr_rd_idx,
  input wire eer_pkg::eer_size_t gpr_rd_size,
  output logic [63:0] gpr_rd_data,
  input wire logic [3:0] sp_idx,
  output logic [63:0] sp_value,
  input wire logic ip_wr,
  input wire logic [63:0] ip_wdata,
  output logic [63:0] ip_value,
  input wire logic flags_wr,
  input wire logic [63:0] flags_wdata,
  output logic [63:0] wide_flags_reg,
  input wire logic vec_wr,
  input wire logic vec_wide,
  input wire logic [3:0] vec_idx,
  input wire logic [255:0] vec_wdata,
  output logic [255:0] vec_rd_data,
  input wire logic sys_wr,
  input wire logic [3:0] sys_sel,
  input wire logic [2:0] sys_sub,
  input wire logic [63:0] sys_wdata,
  input wire logic [15:0] sys_wlimit,
  input wire logic [2:0] sys_rd_sel,
  input wire logic [2:0] sys_rd_sub,
  output logic [79:0] sys_rd_data,
  input wire logic user_level,
  input wire logic msr_rd,
  input wire logic [1:0] msr_idx,
  output logic [63:0] msr_rd_data,
  output logic msr_fault,
  input wire logic reg_ext_wide,
  input wire logic opsize_ovr,
  output eer_pkg::eer_size_t op_size,
  output logic [7:0] phys_addr_width,
  input wire eer_pkg::eer_addr_req_t addr_req,
  output eer_pkg::eer_addr_rsp_t addr_rsp
);
  localparam logic [3:0] SEL_CR = 4'h0;
  localparam logic [3:0] SEL_PRIO = 4'h1;
  localparam logic [3:0] SEL_DBG = 4'h2;
  localparam logic [3:0] SEL_GDT = 4'h3;
  localparam logic [3:0] SEL_IDT = 4'h4;
  localparam logic [3:0] SEL_LDT = 4'h5;
  localparam logic [3:0] SEL_TSK = 4'h6;

  logic [63:0] general_regs_ff [NUM_GPR];
  logic [255:0] vector_regs_ff [NUM_VEC];
  logic [63:0] mode_control_regs_ff [`EER_NUM_CR];
  logic [63:0] debug_watch_regs_ff [8];
  logic [`EER_TASK_PRIO_W-1:0] task_priority_ctrl_ff;
  logic [79:0] global_table_base_reg_ff;
  logic [79:0] interrupt_table_base_reg_ff;
  logic [63:0] local_table_base_reg_ff;
  logic [63:0] task_state_base_reg_ff;
  logic [63:0] ip_ff;
  logic [31:0] flags_reg_32_ff;
  logic [63:0] tsc_ff;
  logic [63:0] gpr_rd_ff;
  logic [255:0] vec_rd_ff;
  logic [79:0] sys_rd_ff;
  logic [63:0] msr_rd_ff;
  logic msr_fault_ff;
  eer_pkg::eer_addr_rsp_t addr_rsp_ff;
  eer_pkg::eer_addr_rsp_t nxt_addr_rsp;

  // Merges a byte or word write into the old value; a dword write clears bits 63:32; byte always lands in bits 7:0.
  function automatic logic [63:0] size_merge(input logic [63:0] old, input logic [63:0] wd,
                                             input eer_pkg::eer_size_t sz);
    case (sz)
      eer_pkg::EER_SZ_BYTE: size_merge = {old[63:8], wd[7:0]};
      eer_pkg::EER_SZ_WORD: size_merge = {old[63:16], wd[15:0]};
      eer_pkg::EER_SZ_DWORD: size_merge = {32'h0000_0000, wd[31:0]};
      default: size_merge = wd;
    endcase
  endfunction

  function automatic logic [63:0] size_mask(input logic [63:0] v, input eer_pkg::eer_size_t sz);
    case (sz)
      eer_pkg::EER_SZ_BYTE: size_mask = {56'h0, v[7:0]};
      eer_pkg::EER_SZ_WORD: size_mask = {48'h0, v[15:0]};
      eer_pkg::EER_SZ_DWORD: size_mask = {32'h0, v[31:0]};
      default: size_mask = v;
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GPR; gi++) begin : g_gpr
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          general_regs_ff[gi] <= 64'h0;
        end else if (clk_en && gpr_req.wr && gpr_req.idx == 4'(gi)) begin
          general_regs_ff[gi] <= size_merge(general_regs_ff[gi], gpr_req.data, gpr_req.size);
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gpr_rd_ff <= 64'h0;
    end else if (clk_en) begin
      gpr_rd_ff <= size_mask(general_regs_ff[gpr_rd_idx], gpr_rd_size);
    end
  end
  assign gpr_rd_data = gpr_rd_ff;

  assign sp_value = general_regs_ff[sp_idx];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ip_ff <= `EER_RIP_RESET;
    end else if (clk_en && ip_wr) begin
      ip_ff <= wide_mode ? ip_wdata : {32'h0, ip_wdata[31:0]};
    end
  end
  assign ip_value = ip_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flags_reg_32_ff <= `EER_FLAGS_RESET;
    end else if (clk_en && flags_wr) begin
      flags_reg_32_ff <= flags_wdata[31:0] | `EER_FLAGS_RESET;
    end
  end
  assign wide_flags_reg = {32'h0000_0000, flags_reg_32_ff};

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      vec_rd_ff <= 256'h0;
    end else if (clk_en) begin
      if (vec_wr) begin
        vector_regs_ff[vec_idx] <= vec_wide ? vec_wdata
                                   : {vector_regs_ff[vec_idx][255:128], vec_wdata[127:0]};
      end
      vec_rd_ff <= vector_regs_ff[vec_idx];
    end
  end
  assign vec_rd_data = vec_rd_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < `EER_NUM_CR; i++) begin
        mode_control_regs_ff[i] <= 64'h0;
      end
      for (int i = 0; i < 8; i++) begin
        debug_watch_regs_ff[i] <= 64'h0;
      end
      task_priority_ctrl_ff <= '0;
    end else if (clk_en && sys_wr) begin
      if (sys_sel == SEL_CR && sys_sub < 3'(`EER_NUM_CR)) begin
        mode_control_regs_ff[sys_sub] <= wide_mode ? sys_wdata : {32'h0, sys_wdata[31:0]};
      end
      if (sys_sel == SEL_DBG) begin
        debug_watch_regs_ff[sys_sub] <= wide_mode ? sys_wdata : {32'h0, sys_wdata[31:0]};
      end
      if (sys_sel == SEL_PRIO && wide_mode) begin
        task_priority_ctrl_ff <= sys_wdata[`EER_TASK_PRIO_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      global_table_base_reg_ff <= 80'h0;
      interrupt_table_base_reg_ff <= 80'h0;
      local_table_base_reg_ff <= 64'h0;
      task_state_base_reg_ff <= 64'h0;
    end else if (clk_en && sys_wr) begin
      case (sys_sel)
        SEL_GDT: global_table_base_reg_ff <= {sys_wdata, sys_wlimit};
        SEL_IDT: interrupt_table_base_reg_ff <= {sys_wdata, sys_wlimit};
        SEL_LDT: local_table_base_reg_ff <= sys_wdata;
        SEL_TSK: task_state_base_reg_ff <= sys_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sys_rd_ff <= 80'h0;
    end else if (clk_en) begin
      case (sys_rd_sel)
        3'h0: sys_rd_ff <= (sys_rd_sub < 3'(`EER_NUM_CR))
                           ? {16'h0, mode_control_regs_ff[sys_rd_sub]} : 80'h0;
        3'h1: sys_rd_ff <= {76'h0, task_priority_ctrl_ff};
        3'h2: sys_rd_ff <= {16'h0, debug_watch_regs_ff[sys_rd_sub]};
        3'h3: sys_rd_ff <= global_table_base_reg_ff;
        3'h4: sys_rd_ff <= interrupt_table_base_reg_ff;
        3'h5: sys_rd_ff <= {16'h0, local_table_base_reg_ff};
        3'h6: sys_rd_ff <= {16'h0, task_state_base_reg_ff};
        default: sys_rd_ff <= 80'h0;
      endcase
    end
  end
  assign sys_rd_data = sys_rd_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tsc_ff <= 64'h0;
      msr_rd_ff <= 64'h0;
      msr_fault_ff <= 1'b0;
    end else if (clk_en) begin
      tsc_ff <= tsc_ff + 64'h1;
      msr_fault_ff <= msr_rd && user_level && msr_idx != `EER_MSR_TSC;
      if (msr_rd) begin
        msr_rd_ff <= (msr_idx == `EER_MSR_TSC) ? tsc_ff : 64'h0;
      end
    end
  end
  assign msr_rd_data = msr_rd_ff;
  assign msr_fault = msr_fault_ff;

  always_comb begin
    if (wide_mode && reg_ext_wide) begin
      op_size = eer_pkg::EER_SZ_QWORD;
    end else if (opsize_ovr) begin
      op_size = eer_pkg::EER_SZ_WORD;
    end else begin
      op_size = eer_pkg::EER_SZ_DWORD;
    end
  end

  assign phys_addr_width = wide_mode ? 8'(PHYS_W) : 8'(`EER_PHYS_W_LEGACY);

  always_comb begin
    logic [63:0] lin;
    logic bad;
    lin = 64'h0;
    bad = 1'b0;
    case (addr_req.model)
      eer_pkg::EER_MDL_FLAT: begin
        lin = {32'h0, addr_req.offset[31:0]};
      end
      eer_pkg::EER_MDL_SEG: begin
        // Offset past the limit or an index beyond the table count is a fault.
        bad = addr_req.offset[63:32] != 32'h0 || addr_req.offset[31:0] > addr_req.seg_limit
              || addr_req.seg_index > `EER_SEG_MAX || addr_req.seg_index == 14'h0;
        lin = {32'h0, addr_req.seg_base[31:0] + addr_req.offset[31:0]};
      end
      eer_pkg::EER_MDL_REAL: begin
        bad = addr_req.offset[63:16] != 48'h0;
        lin = {44'h0, 20'(addr_req.seg_base[19:0] + {4'h0, addr_req.offset[15:0]})};
      end
      default: begin
        lin = addr_req.offset;
        bad = !wide_mode || lin[63:47] != {17{lin[47]}};
      end
    endcase
    nxt_addr_rsp.valid = addr_req.req;
    nxt_addr_rsp.fault = addr_req.req && bad;
    nxt_addr_rsp.linear = bad ? 64'h0 : lin;
    nxt_addr_rsp.phys = bad ? 46'h0
                        : (wide_mode ? lin[45:0] : {10'h0, lin[35:0]});
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      addr_rsp_ff <= '0;
    end else if (clk_en) begin
      addr_rsp_ff <= nxt_addr_rsp;
    end
  end
  assign addr_rsp = addr_rsp_ff;

  property p_byte_low;
    @(posedge core_clk) disable iff (!rst_b)
      clk_en && gpr_rd_size == eer_pkg::EER_SZ_BYTE |=> gpr_rd_data[63:8] == 56'h0;
  endproperty
  a_byte_low: assert property (p_byte_low) else $error("byte read not low eight bits");

  property p_flags_upper;
    @(posedge core_clk) disable iff (!rst_b) wide_flags_reg[63:32] == 32'h0;
  endproperty
  a_flags_upper: assert property (p_flags_upper) else $error("reserved flags nonzero");

  property p_ip_wide;
    @(posedge core_clk) disable iff (!rst_b)
      clk_en && ip_wr && wide_mode |=> ip_value == $past(ip_wdata);
  endproperty
  a_ip_wide: assert property (p_ip_wide) else $error("ip not held at 64 bits");

  property p_msr_user;
    @(posedge core_clk) disable iff (!rst_b)
      clk_en && msr_rd && user_level |=> msr_fault == ($past(msr_idx) != `EER_MSR_TSC);
  endproperty
  a_msr_user: assert property (p_msr_user) else $error("msr user gate wrong");

  property p_real_limit;
    @(posedge core_clk) disable iff (!rst_b)
      clk_en && addr_req.req && addr_req.model == eer_pkg::EER_MDL_REAL
      |=> addr_rsp.linear[63:20] == 44'h0;
  endproperty
  a_real_limit: assert property (p_real_limit) else $error("real address over 20 bits");

  property p_flat_limit;
    @(posedge core_clk) disable iff (!rst_b)
      clk_en && addr_req.req && addr_req.model == eer_pkg::EER_MDL_FLAT
      |=> addr_rsp.valid && !addr_rsp.fault && addr_rsp.linear[63:32] == 32'h0;
  endproperty
  a_flat_limit: assert property (p_flat_limit) else $error("flat address wrong");

  property p_legacy_phys;
    @(posedge core_clk) disable iff (!rst_b) !wide_mode |-> phys_addr_width == 8'h24;
  endproperty
  a_legacy_phys: assert property (p_legacy_phys) else $error("legacy width not 36");

  property p_opsize;
    @(posedge core_clk) disable iff (!rst_b)
      wide_mode && !reg_ext_wide && !opsize_ovr |-> op_size == eer_pkg::EER_SZ_DWORD;
  endproperty
  a_opsize: assert property (p_opsize) else $error("default operand not 32 bits");
endmodule
`default_nettype wire

// [design/eer_defines.svh]
// Constants for the execution environment register file and address unit.
`ifndef EER_DEFINES_SVH
`define EER_DEFINES_SVH
`define EER_NUM_GPR 16
`define EER_NUM_VEC 16
`define EER_NUM_CR 5
`define EER_TASK_PRIO_W 4
`define EER_PHYS_W_WIDE 46
`define EER_PHYS_W_LEGACY 36
`define EER_FLAT_W 32
`define EER_REAL_W 20
`define EER_SEG_MAX 14'h3fff
`define EER_MSR_TSC 2'h0
`define EER_RIP_RESET 64'h0000_0000_0000_fff0
`define EER_FLAGS_RESET 32'h0000_0002
`endif

// [design/eer_pkg.sv]
// Types shared by the execution environment register file.
package eer_pkg;
  typedef enum logic [1:0] {
    EER_SZ_BYTE,
    EER_SZ_WORD,
    EER_SZ_DWORD,
    EER_SZ_QWORD
  } eer_size_t;

  typedef enum logic [1:0] {
    EER_MDL_FLAT,
    EER_MDL_SEG,
    EER_MDL_REAL,
    EER_MDL_WIDE
  } eer_model_t;

  typedef struct packed {
    logic wr;
    logic [3:0] idx;
    eer_size_t size;
    logic [63:0] data;
  } eer_gpr_req_t;

  typedef struct packed {
    logic req;
    eer_model_t model;
    logic [13:0] seg_index;
    logic [63:0] seg_base;
    logic [31:0] seg_limit;
    logic [63:0] offset;
  } eer_addr_req_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [63:0] linear;
    logic [45:0] phys;
  } eer_addr_rsp_t;
endpackage

// [verification/eer_phys_mem.sv]
// Behavioural physical memory answering byte reads at translated addresses.
`timescale 1ns/1ps
`default_nettype none
module eer_phys_mem (
  input wire logic core_clk,
  input wire eer_pkg::eer_addr_rsp_t addr_rsp,
  output logic [7:0] rd_byte
);
  always_ff @(posedge core_clk) begin
    if (addr_rsp.valid && !addr_rsp.fault) begin
      rd_byte <= addr_rsp.phys[7:0] ^ addr_rsp.phys[15:8];
    end else begin
      // An idle bus inverts the byte every cycle, so a stale byte reads true again after two idle cycles.
      rd_byte <= ~rd_byte;
    end
  end
endmodule
`default_nettype wire

// [verification/test_eer_core_state.sv]
// Self-checking bench for the core register file and address unit.
`timescale 1ns/1ps
`default_nettype none
module test_eer_core_state;
  localparam eer_pkg::eer_size_t sz_b = eer_pkg::EER_SZ_BYTE;
  localparam eer_pkg::eer_size_t sz_w = eer_pkg::EER_SZ_WORD;
  localparam eer_pkg::eer_size_t sz_d = eer_pkg::EER_SZ_DWORD;
  localparam eer_pkg::eer_size_t sz_q = eer_pkg::EER_SZ_QWORD;
  localparam eer_pkg::eer_model_t md_f = eer_pkg::EER_MDL_FLAT;
  localparam eer_pkg::eer_model_t md_s = eer_pkg::EER_MDL_SEG;
  localparam eer_pkg::eer_model_t md_r = eer_pkg::EER_MDL_REAL;
  localparam eer_pkg::eer_model_t md_w = eer_pkg::EER_MDL_WIDE;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic wide_mode = 1'b1;
  eer_pkg::eer_gpr_req_t gpr_req = '0;
  logic [3:0] gpr_rd_idx = 4'h0;
  eer_pkg::eer_size_t gpr_rd_size = eer_pkg::EER_SZ_QWORD;
  logic [3:0] sp_idx = 4'h0;
  logic ip_wr = 1'b0;
  logic [63:0] ip_wdata = 64'h0;
  logic flags_wr = 1'b0;
  logic [63:0] flags_wdata = 64'h0;
  logic vec_wr = 1'b0;
  logic vec_wide = 1'b0;
  logic [3:0] vec_idx = 4'h0;
  logic [255:0] vec_wdata = 256'h0;
  logic sys_wr = 1'b0;
  logic [3:0] sys_sel = 4'h0;
  logic [2:0] sys_sub = 3'h0;
  logic [63:0] sys_wdata = 64'h0;
  logic [15:0] sys_wlimit = 16'h0;
  logic [2:0] sys_rd_sel = 3'h0;
  logic [2:0] sys_rd_sub = 3'h0;
  logic user_level = 1'b0;
  logic msr_rd = 1'b0;
  logic [1:0] msr_idx = 2'h0;
  logic reg_ext_wide = 1'b0;
  logic opsize_ovr = 1'b0;
  eer_pkg::eer_addr_req_t addr_req = '0;
  logic [63:0] gpr_rd_data, sp_value, ip_value, wide_flags_reg, msr_rd_data;
  logic [255:0] vec_rd_data;
  logic [79:0] sys_rd_data;
  logic msr_fault;
  eer_pkg::eer_size_t op_size;
  logic [7:0] phys_addr_width, rd_byte;
  eer_pkg::eer_addr_rsp_t addr_rsp;
  int n_mismatch = 0;
  int checks_done = 0;

  eer_core_state i_eer_core_state (.core_clk, .rst_b, .clk_en, .wide_mode, .gpr_req,
    .gpr_rd_idx, .gpr_rd_size, .gpr_rd_data, .sp_idx, .sp_value, .ip_wr, .ip_wdata,
    .ip_value, .flags_wr, .flags_wdata, .wide_flags_reg, .vec_wr, .vec_wide, .vec_idx,
    .vec_wdata, .vec_rd_data, .sys_wr, .sys_sel, .sys_sub, .sys_wdata, .sys_wlimit,
    .sys_rd_sel, .sys_rd_sub, .sys_rd_data, .user_level, .msr_rd, .msr_idx, .msr_rd_data,
    .msr_fault, .reg_ext_wide, .opsize_ovr, .op_size, .phys_addr_width, .addr_req, .addr_rsp);
  eer_phys_mem i_eer_phys_mem (.core_clk, .addr_rsp, .rd_byte);

  always #5 core_clk = ~core_clk;

  task automatic cyc(input int n = 1);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Writes open with an idle edge so a strobe is never lowered and raised in one step.
  task automatic gw(input logic [3:0] i, input eer_pkg::eer_size_t s, input logic [63:0] d);
    cyc();
    gpr_req <= '{wr: 1'b1, idx: i, size: s, data: d};
    cyc();
    gpr_req.wr <= 1'b0;
  endtask
  task automatic gr(input logic [3:0] i, input eer_pkg::eer_size_t s, input logic [63:0] e);
    gpr_rd_idx <= i;
    gpr_rd_size <= s;
    cyc();
    #1 chk(gpr_rd_data, e);
    cyc();
  endtask
  task automatic t_gpr;
    gw(4'hf, sz_q, 64'h0123_4567_89ab_cdef);
    gr(4'hf, sz_q, 64'h0123_4567_89ab_cdef);
    gw(4'hf, sz_b, 64'hffff_ffff_ffff_ff5a);
    gr(4'hf, sz_q, 64'h0123_4567_89ab_cd5a);
    gr(4'hf, sz_b, 64'h5a);
    gw(4'h0, sz_q, 64'hffff_ffff_ffff_ffff);
    gw(4'h0, sz_w, 64'h1234);
    gr(4'h0, sz_q, 64'hffff_ffff_ffff_1234);
    gw(4'h0, sz_d, 64'h8765_4321);
    gr(4'h0, sz_q, 64'h8765_4321);
    gr(4'h0, sz_w, 64'h4321);
    sp_idx <= 4'hf;
    opsize_ovr <= 1'b1;
    wide_mode <= 1'b0;
    #1 chk(sp_value, 64'h0123_4567_89ab_cd5a);
    cyc();
    opsize_ovr <= 1'b0;
    wide_mode <= 1'b1;
  endtask
  task automatic t_ipf;
    ip_wr <= 1'b1;
    ip_wdata <= 64'hfedc_ba98_7654_3210;
    flags_wr <= 1'b1;
    flags_wdata <= 64'hffff_ffff_ffff_fffd;
    cyc();
    ip_wr <= 1'b0;
    flags_wr <= 1'b0;
    #1 chk(ip_value, 64'hfedc_ba98_7654_3210);
    chk(wide_flags_reg, 64'hffff_ffff);
    cyc();
  endtask
  task automatic t_vec;
    vec_wr <= 1'b1;
    vec_wide <= 1'b1;
    vec_idx <= 4'hf;
    vec_wdata <= {4{64'h0123_4567_89ab_cdef}};
    cyc();
    vec_wide <= 1'b0;
    vec_wdata <= {4{64'h5555_aaaa_5555_aaaa}};
    cyc();
    vec_wr <= 1'b0;
    #1 chk(vec_rd_data, {4{64'h0123_4567_89ab_cdef}});
    cyc();
    #1 chk(vec_rd_data, {{2{64'h0123_4567_89ab_cdef}}, {2{64'h5555_aaaa_5555_aaaa}}});
    cyc();
  endtask
  task automatic sw(input logic [3:0] s, input logic [2:0] u, input logic [63:0] d);
    cyc();
    sys_wr <= 1'b1;
    sys_sel <= s;
    sys_sub <= u;
    sys_wdata <= d;
    sys_wlimit <= d[15:0];
    cyc();
    sys_wr <= 1'b0;
  endtask
  task automatic sr(input logic [2:0] s, input logic [2:0] u);
    sys_rd_sel <= s;
    sys_rd_sub <= u;
    cyc();
    #1;
  endtask
  task automatic t_sys;
    for (int u = 0; u < 5; u++) begin
      sw(4'h0, 3'(u), {16{4'(u + 8)}});
    end
    sw(4'h0, 3'h5, 64'hffff_ffff_ffff_ffff);
    for (int u = 0; u < 6; u++) begin
      sr(3'h0, 3'(u));
      chk(sys_rd_data[63:0], (u < 5) ? {16{4'(u + 8)}} : 64'h0);
      cyc();
    end
    sw(4'h1, 3'h0, 64'ha);
    wide_mode <= 1'b0;
    sw(4'h1, 3'h0, 64'h5);
    wide_mode <= 1'b1;
    sr(3'h1, 3'h0);
    chk(sys_rd_data[3:0], 4'ha);
    cyc();
    sw(4'h2, 3'h7, 64'hdbdb_0000_1111_2222);
    sr(3'h2, 3'h7);
    chk(sys_rd_data[63:0], 64'hdbdb_0000_1111_2222);
    cyc();
    for (int s = 3; s < 7; s++) begin
      logic [63:0] v;
      v = {8{8'(s)}};
      sw(4'(s), 3'h0, v);
      sr(3'(s), 3'h0);
      // Only the global and interrupt tables carry a limit word below the base.
      chk(sys_rd_data, (s < 5) ? {v, v[15:0]} : {16'h0, v});
      cyc();
    end
  endtask
  task automatic mr(input logic u, input logic [1:0] i, input logic f);
    user_level <= u;
    msr_idx <= i;
    msr_rd <= 1'b1;
    cyc();
    msr_rd <= 1'b0;
    #1 chk(msr_fault, f);
    if (f) begin
      chk(msr_rd_data, 64'h0);
    end
    cyc();
  endtask
  task automatic t_msr;
    logic [63:0] t0;
    mr(1'b1, 2'h1, 1'b1);
    mr(1'b0, 2'h1, 1'b0);
    mr(1'b1, 2'h0, 1'b0);
    t0 = msr_rd_data;
    clk_en <= 1'b0;
    cyc(3);
    clk_en <= 1'b1;
    mr(1'b1, 2'h0, 1'b0);
    chk(msr_rd_data - t0, 64'h2);
  endtask
  task automatic t_ops;
    for (int i = 0; i < 8; i++) begin
      {wide_mode, reg_ext_wide, opsize_ovr} <= 3'(i);
      #1 chk(op_size, (i >= 6) ? sz_q : (i[0] ? sz_w : sz_d));
      chk(phys_addr_width, (i < 4) ? 8'h24 : 8'h2e);
      cyc();
    end
    wide_mode <= 1'b0;
  endtask
  task automatic ar(input eer_pkg::eer_model_t m, input logic [13:0] x, input logic [63:0] b,
      input logic [63:0] o, input logic f, input logic [63:0] l, input logic [45:0] p);
    cyc();
    addr_req <= '{req: 1'b1, model: m, seg_index: x, seg_base: b, seg_limit: 32'hffff,
      offset: o};
    cyc();
    addr_req.req <= 1'b0;
    #1 chk({addr_rsp.valid, addr_rsp.fault}, {1'b1, f});
    chk(addr_rsp.linear, l);
    chk(addr_rsp.phys, p);
    cyc();
    #1 if (!f) begin
      chk(rd_byte, p[7:0] ^ p[15:8]);
    end
  endtask
  task automatic t_addr;
    ar(md_f, 14'h0, 64'h0, 64'hffff_ffff, 1'b0, 64'hffff_ffff, 46'hffff_ffff);
    ar(md_s, 14'h3fff, 64'h10_8000_0000, 64'hfffe, 1'b0, 64'h8000_fffe,
      46'h8000_fffe);
    ar(md_s, 14'h0, 64'h0, 64'h10, 1'b1, 64'h0, 46'h0);
    ar(md_s, 14'h1, 64'h0, 64'h1_0000, 1'b1, 64'h0, 46'h0);
    ar(md_r, 14'h0, 64'hf_fff0, 64'h20, 1'b0, 64'h10, 46'h10);
    ar(md_r, 14'h0, 64'h0, 64'h1_0000, 1'b1, 64'h0, 46'h0);
    ar(md_w, 14'h0, 64'h0, 64'h10, 1'b1, 64'h0, 46'h0);
    wide_mode <= 1'b1;
    ar(md_w, 14'h0, 64'h0, 64'h0000_8000_0000_0000, 1'b1, 64'h0, 46'h0);
    ar(md_w, 14'h0, 64'h0, 64'hffff_a345_6789_abcd, 1'b0, 64'hffff_a345_6789_abcd,
      46'h2345_6789_abcd);
  endtask

  // A reset in mid-run must restore the reset values over state written earlier.
  task automatic t_rst;
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    #1 chk(ip_value, 64'hfff0);
    chk(wide_flags_reg, 64'h2);
    chk(sys_rd_data, 80'h0);
    gr(4'hf, sz_q, 64'h0);
  endtask

  initial begin
    cyc(16);
    rst_b <= 1'b1;
    #1 chk(ip_value, 64'hfff0);
    chk(wide_flags_reg, 64'h2);
    t_gpr();
    t_ipf();
    t_vec();
    t_sys();
    t_msr();
    t_ops();
    t_addr();
    t_rst();
    final_report();
  end
  // A hang is cut short here and counted as a mismatch.
  initial begin
    cyc(20000);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
